// >>> adc_ctrl_pkg.sv
// Constants, register map and carrier types for the manual-trigger converter control block
package adc_ctrl_pkg;

  // ************************************************************
  // Register port
  // ************************************************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_AUTO = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_RES_HI = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_RES_LO = 3'h6;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_START = 0;
  localparam int BIT_BUSY = 1;
  localparam int BIT_POWER = 2;
  localparam int CH_LSB = 4;
  localparam int DIV_LSB = 0;
  localparam int SRC_LSB = 4;
  localparam int AUTO_LSB = 0;
  localparam int IRQ_DONE = 0;

  // ************************************************************
  // Codes, timing and reset values
  // ************************************************************
  localparam int DIV_CNT_W = 7;
  localparam int RES_W = 12;
  localparam logic [4:0] SAMPLE_CYCLES = 5'h04;
  localparam logic [4:0] CONV_CYCLES = 5'h0c;
  localparam logic [3:0] LAST_CNT = 4'(SAMPLE_CYCLES + CONV_CYCLES - 5'h01);
  localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_CYCLES - 5'h01);
  localparam logic [3:0] EXT_CH_MAX = 4'ha;
  localparam logic [2:0] SRC_INT_LO = 3'h1;
  localparam logic [2:0] SRC_INT_HI = 3'h4;
  localparam logic [2:0] AUTO_MANUAL = 3'h0;
  localparam logic [2:0] DIV_UNDIVIDED = 3'h0;
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;

  typedef enum logic [1:0] {ST_IDLE, ST_ALIGN, ST_RUN} conv_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic power_on;
    logic conv_tick;
    logic sampling;
    logic converting;
    logic ext_route;
    logic ext_float;
    logic [3:0] ext_ch;
    logic [2:0] int_sel;
  } core_drive_t;

endpackage

// >>> adc_manual_conversion_ctrl.sv
// Manual-trigger converter control: clock divider, start pulse, 16-period sequence, busy and interrupt
// What this block does
// RULE_01 - Divide system clock by two to the select
// RULE_02 - Software keeps conversion clock within allowed period
// RULE_03 - Converter powered exactly while power bit high
// RULE_04 - Software waits settling delay before starting
// RULE_05 - Four sampling plus twelve conversion periods
// RULE_06 - Manual mode only when auto count zero
// RULE_07 - Start pulse low-high-low begins one conversion
// RULE_08 - Busy set on start, cleared on completion
// RULE_09 - Completion sets interrupt flag, raises interrupt
// RULE_10 - Software may poll busy instead of interrupt
// RULE_11 - Software sets divide, power, then source
// RULE_12 - Software configures pin for external channel
// RULE_13 - Source and channel codes route the input
// RULE_14 - Software reads result only after busy low
// RULE_15 - Sequence starts at falling start edge, clocked
`timescale 1ns/10ps
module adc_manual_conversion_ctrl (
  input wire logic clk,
  input wire logic rstn,
  input wire adc_ctrl_pkg::reg_req_t reg_req,
  output logic [adc_ctrl_pkg::DATA_W-1:0] rdata,
  input wire logic [adc_ctrl_pkg::RES_W-1:0] core_result,
  output adc_ctrl_pkg::core_drive_t core_drive,
  output logic irq
);
  import adc_ctrl_pkg::*;

  // ************************************************************
  // Decoders
  // ************************************************************
  function automatic logic [DIV_CNT_W-1:0] div_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = (8'h01 << sel) - 8'h01;
    return m[DIV_CNT_W-1:0];
  endfunction

  function automatic logic is_ext_source(input logic [2:0] src);
    return !(src >= SRC_INT_LO && src <= SRC_INT_HI);
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  logic start_q;
  logic start_prev_q;
  logic power_q;
  logic [3:0] ch_q;
  logic [2:0] div_sel_q;
  logic [2:0] src_q;
  logic [2:0] auto_q;
  logic [DATA_W-1:0] irq_stat_q;
  logic [DATA_W-1:0] irq_mask_q;
  logic [RES_W-1:0] result_q;
  logic [DATA_W-1:0] rdata_q;
  logic busy_q;
  logic [DIV_CNT_W-1:0] div_cnt_q;
  logic [3:0] cnt_q;
  conv_state_t state_q;

  logic tick;
  logic start_fall;
  logic accept;
  logic done;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_auto;
  logic wr_stat;
  logic wr_mask;

  assign wr_ctrl0 = reg_req.wr && reg_req.addr == OFS_CTRL0;
  assign wr_ctrl1 = reg_req.wr && reg_req.addr == OFS_CTRL1;
  assign wr_auto = reg_req.wr && reg_req.addr == OFS_AUTO;
  assign wr_stat = reg_req.wr && reg_req.addr == OFS_IRQ_STAT;
  assign wr_mask = reg_req.wr && reg_req.addr == OFS_IRQ_MASK;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_q <= 1'b0;
      power_q <= 1'b0;
      ch_q <= 4'h0;
    end else if (wr_ctrl0) begin
      start_q <= reg_req.wdata[BIT_START];
      power_q <= reg_req.wdata[BIT_POWER];
      ch_q <= reg_req.wdata[CH_LSB +: 4];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_sel_q <= DIV_UNDIVIDED;
      src_q <= 3'h0;
    end else if (wr_ctrl1) begin
      div_sel_q <= reg_req.wdata[DIV_LSB +: 3];
      src_q <= reg_req.wdata[SRC_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      auto_q <= AUTO_MANUAL;
    end else if (wr_auto) begin
      auto_q <= reg_req.wdata[AUTO_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_q <= REG_RST;
    end else if (wr_mask) begin
      irq_mask_q <= reg_req.wdata;
    end
  end

  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= REG_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? reg_req.wdata : REG_RST))
                    | (done ? (8'h01 << IRQ_DONE) : REG_RST); // [RULE_09]
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= REG_RST;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        OFS_CTRL0: rdata_q <= {ch_q, 1'b0, power_q, busy_q, start_q}; // [RULE_10]
        OFS_CTRL1: rdata_q <= {1'b0, src_q, 1'b0, div_sel_q};
        OFS_AUTO: rdata_q <= {5'h00, auto_q};
        OFS_IRQ_STAT: rdata_q <= irq_stat_q;
        OFS_IRQ_MASK: rdata_q <= irq_mask_q;
        OFS_RES_HI: rdata_q <= {4'h0, result_q[RES_W-1:DATA_W]};
        OFS_RES_LO: rdata_q <= result_q[DATA_W-1:0];
        default: rdata_q <= REG_RST;
      endcase
    end else begin
      rdata_q <= REG_RST;
    end
  end
  assign rdata = rdata_q;

  // ************************************************************
  // Conversion clock divider
  // ************************************************************
  // Free running, so a new divide takes effect without restarting the count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 7'h01;
    end
  end
  assign tick = (div_cnt_q & div_mask(div_sel_q)) == div_mask(div_sel_q); // [RULE_01]

  // ************************************************************
  // Start detection and sequence
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_q;
    end
  end
  assign start_fall = start_prev_q && !start_q; // [RULE_07] [RULE_15]
  // Pulses outside manual mode, unpowered or while busy are ignored
  assign accept = start_fall && auto_q == AUTO_MANUAL && power_q && state_q == ST_IDLE; // [RULE_06]
  assign done = state_q == ST_RUN && tick && cnt_q == LAST_CNT && power_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= 4'h0;
          if (accept) begin
            state_q <= ST_ALIGN; // [RULE_07]
          end
        end
        ST_ALIGN: begin
          if (!power_q) begin
            state_q <= ST_IDLE;
          end else if (tick) begin
            state_q <= ST_RUN; // [RULE_15]
          end
        end
        ST_RUN: begin
          if (!power_q || done) begin
            state_q <= ST_IDLE;
          end else if (tick) begin
            cnt_q <= cnt_q + 4'h1; // [RULE_05]
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Dropping power aborts the conversion with no completion event
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
    end else if (accept) begin
      busy_q <= 1'b1; // [RULE_08]
    end else if (done || !power_q) begin
      busy_q <= 1'b0; // [RULE_08]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_q <= RES_RST;
    end else if (done) begin
      result_q <= core_result;
    end
  end

  // ************************************************************
  // Core drive and interrupt
  // ************************************************************
  always_comb begin
    core_drive.power_on = power_q; // [RULE_03]
    core_drive.conv_tick = tick && state_q == ST_RUN;
    core_drive.sampling = state_q == ST_RUN && cnt_q <= SAMPLE_LAST; // [RULE_05]
    core_drive.converting = state_q == ST_RUN && cnt_q > SAMPLE_LAST; // [RULE_05]
    core_drive.ext_route = is_ext_source(src_q) && ch_q <= EXT_CH_MAX; // [RULE_13]
    core_drive.ext_float = is_ext_source(src_q) && ch_q > EXT_CH_MAX; // [RULE_13]
    core_drive.ext_ch = ch_q;
    core_drive.int_sel = is_ext_source(src_q) ? 3'h0 : src_q; // [RULE_13]
  end

  assign irq = |(irq_stat_q & irq_mask_q); // [RULE_09]

  // ************************************************************
  // Checks
  // ************************************************************
  undivided_tick_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_01]
    div_sel_q == DIV_UNDIVIDED |-> tick)
    else $error("Undivided clock missed a tick");

  div_by_two_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_01]
    (tick && div_sel_q == 3'h1 && !wr_ctrl1) |=> !tick)
    else $error("Divide by two ticked twice in a row");

  power_follow_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_03]
    $rose(power_q) |-> core_drive.power_on ##1 (core_drive.power_on || $past(wr_ctrl0)))
    else $error("Converter power not following the power bit");

  sample_phase_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_05]
    (state_q == ST_RUN && tick && cnt_q == SAMPLE_LAST && power_q) |=> core_drive.converting)
    else $error("Sampling did not end after four periods");

  run_first_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_05]
    (state_q == ST_ALIGN && tick && power_q) |=> core_drive.sampling && cnt_q == 4'h0)
    else $error("Sequence did not open with sampling");

  manual_only_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_06]
    (state_q == ST_IDLE && auto_q != AUTO_MANUAL) |=> state_q == ST_IDLE)
    else $error("Conversion started outside manual mode");

  start_busy_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_07]
    (start_fall && auto_q == AUTO_MANUAL && power_q && !busy_q) |=> busy_q && state_q == ST_ALIGN)
    else $error("Start pulse did not make the block busy");

  done_clear_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_08]
    done |=> !busy_q && irq_stat_q[IRQ_DONE] && state_q == ST_IDLE)
    else $error("Completion did not clear busy and set the flag");

  irq_level_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_09]
    (irq_stat_q[IRQ_DONE] && irq_mask_q[IRQ_DONE]) |-> irq)
    else $error("Unmasked completion flag without interrupt");

  route_ext_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_13]
    (src_q == 3'h0 && ch_q > EXT_CH_MAX) |-> core_drive.ext_float && !core_drive.ext_route)
    else $error("Unused channel code not left floating");

  start_edge_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_15]
    (state_q == ST_IDLE && !start_fall) |=> state_q == ST_IDLE)
    else $error("Sequence left idle without a falling start edge");

  div_rest_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_01]
    (tick && div_sel_q != DIV_UNDIVIDED && !wr_ctrl1) |=> !tick)
    else $error("Divided clock ticked on two cycles in a row");

  div_period_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_01]
    (tick && div_sel_q == 3'h1 && !wr_ctrl1) ##1 !wr_ctrl1 |=> tick)
    else $error("Divide by two missed its second tick");

  power_abort_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_03]
    (state_q != ST_IDLE && !power_q) |=> state_q == ST_IDLE && !busy_q)
    else $error("Sequence kept running with the power bit low");

  count_hold_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_05]
    (state_q == ST_RUN && !tick && power_q) |=> $stable(cnt_q) && state_q == ST_RUN)
    else $error("Period counter moved between conversion ticks");

  count_step_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_05]
    (state_q == ST_RUN && tick && power_q && cnt_q != LAST_CNT) |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("Period counter did not advance on a tick");

  busy_refuse_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_07]
    (start_fall && state_q != ST_IDLE && power_q && !done) |=> state_q != ST_IDLE)
    else $error("Start pulse while busy disturbed the conversion");

  busy_match_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_08]
    busy_q == (state_q != ST_IDLE))
    else $error("Busy flag disagrees with the sequence state");

  busy_read_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_08]
    (reg_req.rd && reg_req.addr == OFS_CTRL0) |=> rdata[BIT_BUSY] == $past(busy_q))
    else $error("Busy bit read back wrong");

  abort_flag_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_09]
    (!power_q && !irq_stat_q[IRQ_DONE]) |=> !irq_stat_q[IRQ_DONE])
    else $error("Completion flag set while unpowered");

  stat_clear_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_09]
    (wr_stat && reg_req.wdata[IRQ_DONE] && !done) |=> !irq_stat_q[IRQ_DONE])
    else $error("Write one did not clear the completion flag");

  irq_source_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_09]
    irq |-> irq_stat_q[IRQ_DONE] && irq_mask_q[IRQ_DONE])
    else $error("Interrupt raised without an unmasked completion flag");

  route_int_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_13]
    (src_q >= SRC_INT_LO && src_q <= SRC_INT_HI) |-> !core_drive.ext_route && !core_drive.ext_float
      && core_drive.int_sel == src_q)
    else $error("Internal source left an external channel connected");

  route_ch_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_13]
    ((src_q < SRC_INT_LO || src_q > SRC_INT_HI) && ch_q <= EXT_CH_MAX) |-> core_drive.ext_route
      && !core_drive.ext_float && core_drive.int_sel == 3'h0)
    else $error("External channel not routed");

  align_wait_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_15]
    (state_q == ST_ALIGN && !tick && power_q) |=> state_q == ST_ALIGN)
    else $error("Sequence began off a conversion clock tick");

endmodule // adc_manual_conversion_ctrl

// >>> adc_core_model.sv
// Behavioural model of the analog sampling and conversion core
`timescale 1ns/10ps
module adc_core_model (
  input wire logic clk,
  input wire logic rstn,
  input wire adc_ctrl_pkg::core_drive_t core_drive,
  output logic [adc_ctrl_pkg::RES_W-1:0] core_result
);
  import adc_ctrl_pkg::*;
  logic [RES_W-1:0] junk_q;
  // ************************************************************
  // Result
  // ************************************************************
  // Garbage outside a powered sequence, so a capture at the wrong moment shows up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      junk_q <= 12'h5a5;
    end else begin
      junk_q <= ~junk_q + 12'h3b1;
    end
  end
  assign core_result = (core_drive.power_on && (core_drive.sampling || core_drive.converting)) ?
    {4'h9, 1'b0, core_drive.int_sel, core_drive.ext_ch} : junk_q;
endmodule // adc_core_model

// >>> adc_manual_conversion_ctrl_tb_top.sv
// Self-checking testbench for the manual-trigger converter control block
`timescale 1ns/10ps
module adc_manual_conversion_ctrl_tb_top;
  import adc_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  reg_req_t reg_req = '0;
  logic [DATA_W-1:0] rdata;
  logic [RES_W-1:0] core_result;
  core_drive_t core_drive;
  logic irq;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int ticks = 0;
  int samp_ticks = 0;
  int last_tick = 0;
  int bad_gap = 0;
  int gap = 1;
  always #5 clk = ~clk;
  adc_manual_conversion_ctrl u_adc_manual_conversion_ctrl (.clk(clk), .rstn(rstn), .reg_req(reg_req),
    .rdata(rdata), .core_result(core_result), .core_drive(core_drive), .irq(irq));
  adc_core_model u_adc_core_model (.clk(clk), .rstn(rstn), .core_drive(core_drive), .core_result(core_result));
  // ************************************************************
  // Tick monitor
  // ************************************************************
  // The alignment tick before the run is not counted
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (core_drive.conv_tick === 1'b1 && (core_drive.sampling === 1'b1 || core_drive.converting === 1'b1)) begin
      ticks <= ticks + 1;
      if (core_drive.sampling === 1'b1) samp_ticks <= samp_ticks + 1;
      if (ticks > 0 && cyc - last_tick != gap) bad_gap <= bad_gap + 1;
      last_tick <= cyc;
    end
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic test_reset();
    logic [DATA_W-1:0] d;
    check("drive_rst", 16'(core_drive), 16'h0100);
    reg_write(3'h7, 8'hff);
    for (int a = 0; a < 8; a++) begin
      reg_read(3'(a), d);
      check("reg_rst", 16'(d), 16'h0000);
    end
  endtask
  task automatic test_route();
    logic [2:0] s;
    logic [3:0] ch;
    logic ext;
    for (int i = 0; i < 32; i++) begin
      s = 3'(i >> 2);
      ch = (i % 4 == 0) ? 4'h0 : (i % 4 == 1) ? 4'ha : (i % 4 == 2) ? 4'hb : 4'hf;
      ext = (s == 3'h0) || (s >= 3'h5);
      reg_write(OFS_CTRL1, {1'b0, s, 4'h0});
      reg_write(OFS_CTRL0, {ch, 4'h4});
      @(posedge clk);
      #1;
      check("route", {3'h0, core_drive.power_on, core_drive.ext_route, core_drive.ext_float, core_drive.ext_ch,
        3'h0, core_drive.int_sel}, {3'h0, 1'b1, ext && ch <= 4'ha, ext && ch > 4'ha, ch, 3'h0,
        ext ? 3'h0 : s});
    end
    reg_write(OFS_CTRL0, 8'h00);
    @(posedge clk);
    #1;
    check("power_off", 16'(core_drive.power_on), 16'h0000);
  endtask
  task automatic test_refuse();
    logic [DATA_W-1:0] d;
    reg_write(OFS_CTRL0, 8'h74);
    reg_write(OFS_AUTO, 8'h01);
    reg_write(OFS_CTRL0, 8'h75);
    reg_write(OFS_CTRL0, 8'h74);
    repeat (40) @(posedge clk);
    reg_read(OFS_CTRL0, d);
    check("auto_refuse", 16'(d), 16'h0074);
    reg_write(OFS_AUTO, 8'h00);
    reg_write(OFS_CTRL0, 8'h71);
    reg_write(OFS_CTRL0, 8'h70);
    repeat (40) @(posedge clk);
    reg_read(OFS_CTRL0, d);
    check("unpowered", 16'(d), 16'h0070);
    reg_read(OFS_IRQ_STAT, d);
    check("no_flag", 16'(d), 16'h0000);
  endtask
  task automatic test_conv(input logic [2:0] sel);
    logic [DATA_W-1:0] d;
    int n;
    reg_write(OFS_CTRL1, {5'h00, sel});
    reg_write(OFS_CTRL0, 8'h74);
    reg_write(OFS_IRQ_MASK, 8'h01);
    repeat (8) @(posedge clk);
    ticks = 0;
    samp_ticks = 0;
    bad_gap = 0;
    gap = 1 << sel;
    reg_write(OFS_CTRL0, 8'h75);
    reg_read(OFS_CTRL0, d);
    check("no_start_high", 16'(d), 16'h0075);
    reg_write(OFS_CTRL0, 8'h74);
    reg_read(OFS_CTRL0, d);
    check("busy_set", 16'(d), 16'h0076);
    // A second pulse while busy must neither restart nor add a conversion
    reg_write(OFS_CTRL0, 8'h75);
    reg_write(OFS_CTRL0, 8'h74);
    n = 0;
    while (d[BIT_BUSY] !== 1'b0 && n < 1500) begin
      reg_read(OFS_CTRL0, d);
      n++;
    end
    check("busy_clear", 16'(d), 16'h0074);
    check("ticks", 16'(ticks), 16'd16);
    check("samp_ticks", 16'(samp_ticks), 16'd4);
    check("tick_gap", 16'(bad_gap), 16'h0000);
    check("irq_on", 16'(irq), 16'h0001);
    reg_read(OFS_RES_HI, d);
    check("res_hi", 16'(d), 16'h0009);
    reg_read(OFS_RES_LO, d);
    check("res_lo", 16'(d), 16'h0007);
    reg_write(OFS_IRQ_MASK, 8'h00);
    #1;
    check("irq_masked", 16'(irq), 16'h0000);
    reg_read(OFS_IRQ_STAT, d);
    check("stat_kept", 16'(d), 16'h0001);
    reg_write(OFS_IRQ_MASK, 8'h01);
    reg_write(OFS_IRQ_STAT, 8'h01);
    #1;
    check("irq_clear", 16'(irq), 16'h0000);
    reg_read(OFS_IRQ_STAT, d);
    check("stat_clear", 16'(d), 16'h0000);
  endtask
  task automatic test_abort();
    logic [DATA_W-1:0] d;
    reg_write(OFS_CTRL1, {5'h00, 3'h7});
    reg_write(OFS_CTRL0, 8'h74);
    repeat (8) @(posedge clk);
    reg_write(OFS_CTRL0, 8'h75);
    reg_write(OFS_CTRL0, 8'h74);
    reg_read(OFS_CTRL0, d);
    check("abort_busy", 16'(d), 16'h0076);
    reg_write(OFS_CTRL0, 8'h70);
    // Longer than a full divide-by-128 conversion, so a missed abort would complete
    repeat (2200) @(posedge clk);
    reg_read(OFS_CTRL0, d);
    check("abort_idle", 16'(d), 16'h0070);
    reg_read(OFS_IRQ_STAT, d);
    check("abort_flag", 16'(d), 16'h0000);
  endtask
  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    test_reset();
    test_route();
    test_refuse();
    test_conv(3'h0);
    test_conv(3'h1);
    test_conv(3'h3);
    test_conv(3'h7);
    test_abort();
    report_and_stop();
  end
  // Long enough for the divide-by-128 run with ample margin
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule // adc_manual_conversion_ctrl_tb_top
